// ==== rtl/ccdm_top.sv ====
/*
 Recirculating serial memory: 64 loops of 256 bits, all stepped together
 on a rising edge of phase two or phase four, with a 64-bit accessible
 column between shifts. Assumes all pins are asynchronous to clk and are
 filtered here; the controller keeps access and warm-up discipline.
*/
// Functional notes
// [RULE1] Storage is 64 circular loops of 256 bits each.
// [RULE2] A 6-bit address picks exactly one loop for the access.
// [RULE3] Without writes, outgoing bits are fed back so contents persist.
// [RULE4] A rising edge of phase two or four steps all loops.
// [RULE5] After a shift the column bits can be read and overwritten.
// [RULE6] Next shift moves column bits onward and exposes the next position.
// [RULE7] Controller makes no access while a shift is in progress.
// [RULE8] Controller runs 4000 shifts before any access after power-up.
// [RULE9] A read then rewrite of one bit may share one enable period.
// [RULE10] Controller keeps write strobe low throughout a pure read.
// [RULE11] With chip enable low the data output is not driven.
// [RULE12] A write strobe in a selected enabled access stores data in.
// [RULE13] An enabled read shows the complement of the exposed bit.
`include "ccdm_map.svh"
module ccdm_top #(
    parameter int NUM_LOOPS = `CCDM_NUM_LOOPS,
    parameter int LOOP_BITS = `CCDM_LOOP_BITS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic phase1,
    input wire logic phase2,
    input wire logic phase3,
    input wire logic phase4,
    input wire logic [5:0] addr,
    input wire logic chip_sel,
    input wire logic chip_en,
    input wire logic wr_en,
    input wire logic data_in,
    output logic data_out_n,
    output logic data_out_n_oe,
    output logic shift_busy,
    output logic [11:0] shift_count
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_LOOPS != (1 << `CCDM_ADDR_W) || LOOP_BITS < 2) begin : g_bad
        $error("ccdm_top: loop count must match address width");
    end

    // ------------------------------------------------------------
    // Pin filters: three stages, a change counts when stages two and three agree
    // ------------------------------------------------------------
    localparam int NIN = 11;
    logic [NIN-1:0] pins;
    logic [NIN-1:0] s1_q, s2_q, s3_q, f_q;
    logic [NIN-1:0] s1_d, s2_d, s3_d, f_d;
    assign pins = {phase1, phase3, phase2, phase4, addr, chip_sel};
    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
        for (int i = 0; i < NIN; i++) begin
            f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            f_q <= f_d;
        end
    end
    logic [2:0] c1_q, c2_q, c3_q, cf_q, cf_d;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cf_d[i] = (c2_q[i] == c3_q[i]) ? c3_q[i] : cf_q[i];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c1_q <= '0;
            c2_q <= '0;
            c3_q <= '0;
            cf_q <= '0;
        end else begin
            c1_q <= {chip_en, wr_en, data_in};
            c2_q <= c1_q;
            c3_q <= c2_q;
            cf_q <= cf_d;
        end
    end
    logic ph2_f, ph4_f, ce_f, we_f, din_f, cs_f;
    ccdm_pkg::ccdm_addr_t addr_f;
    assign ph2_f = f_q[8];
    assign ph4_f = f_q[7];
    assign addr_f = f_q[6:1];
    assign cs_f = f_q[0];
    assign ce_f = cf_q[2];
    assign we_f = cf_q[1];
    assign din_f = cf_q[0];

    // ------------------------------------------------------------
    // Shift detection
    // ------------------------------------------------------------
    logic ph2_prev_q, ph4_prev_q, shift_now;
    // Both phase filters and their delay flops start low, so reset fakes no edge
    assign shift_now = (ph2_f & ~ph2_prev_q) | (ph4_f & ~ph4_prev_q); // [RULE4]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph2_prev_q <= 1'b0;
            ph4_prev_q <= 1'b0;
        end else begin
            ph2_prev_q <= ph2_f;
            ph4_prev_q <= ph4_f;
        end
    end

    // ------------------------------------------------------------
    // Storage: one array word per bit position; the column register holds the
    // exposed position so reads never disturb the loop
    // ------------------------------------------------------------
    localparam int PW = $clog2(LOOP_BITS);
    ccdm_pkg::ccdm_word_t mem_q [LOOP_BITS]; // [RULE1]
    ccdm_pkg::ccdm_word_t col_q, col_d;
    logic [PW-1:0] pos_q, pos_d, nxt_pos;
    logic [11:0] cnt_q, cnt_d;
    logic wr_hit, rd_hit;
    // A write that meets a shift edge is dropped: the column is being replaced
    assign wr_hit = ce_f & cs_f & we_f & ~shift_now;
    assign rd_hit = ce_f & cs_f;
    assign nxt_pos = (pos_q == PW'(LOOP_BITS - 1)) ? '0 : pos_q + 1'b1;
    always_comb begin
        col_d = col_q;
        pos_d = pos_q;
        cnt_d = cnt_q;
        if (shift_now) begin
            col_d = mem_q[nxt_pos]; // [RULE6]
            pos_d = nxt_pos;
            cnt_d = (cnt_q == 12'hfff) ? cnt_q : cnt_q + 12'h001;
        end else if (wr_hit) begin
            col_d[addr_f] = din_f; // [RULE12] [RULE2] [RULE5] [RULE9]
        end
    end
    always_ff @(posedge clk) begin
        if (shift_now) begin
            mem_q[pos_q] <= col_q; // [RULE3] [RULE6]
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            col_q <= '0;
            pos_q <= '0;
            cnt_q <= '0;
        end else begin
            col_q <= col_d;
            pos_q <= pos_d;
            cnt_q <= cnt_d;
        end
    end
    assign shift_count = cnt_q;
    assign shift_busy = shift_now;

    // ------------------------------------------------------------
    // Open-drain style output: driven only while enabled
    // ------------------------------------------------------------
    logic dout_q, dout_d, oe_q, oe_d;
    always_comb begin
        oe_d = rd_hit; // [RULE11]
        dout_d = ~col_q[addr_f]; // [RULE13]
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end
    // Data keeps following the complement of the addressed column bit while released; the board termination sets the pin
    assign data_out_n = dout_q;
    assign data_out_n_oe = oe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_oe_follows_enable: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        !(ce_f & cs_f) |=> !data_out_n_oe) else $error("output driven while disabled");
    chk_read_complement: assert property (@(posedge clk) disable iff (rst) // [RULE13]
        (ce_f & cs_f) |=> data_out_n === !$past(col_q[addr_f]))
        else $error("read data not complemented");
    chk_write_stores: assert property (@(posedge clk) disable iff (rst) // [RULE12]
        wr_hit |=> col_q[$past(addr_f)] == $past(din_f)) else $error("write lost");
    chk_shift_advance: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        shift_now |=> pos_q == $past(nxt_pos)) else $error("position not advanced");
    chk_hold_still: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        !shift_now && !wr_hit |=> $stable(col_q) && $stable(pos_q))
        else $error("column changed without cause");
    chk_shift_saves: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        shift_now |=> mem_q[$past(pos_q)] === $past(col_q)) else $error("column not saved");
    chk_shift_loads: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        shift_now |=> col_q === $past(mem_q[nxt_pos])) else $error("next column not exposed");
    chk_read_no_harm: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        rd_hit && !we_f && !shift_now |=> $stable(col_q)) else $error("read disturbed data");

    // The loops are not reset, so unwritten bits stay unknown until written, except position 0, which the column reset clears;
    // read, save and load checks use case equality so unknown bits carried round a lap still match
    chk_oe_on_select: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        (ce_f & cs_f) |=> data_out_n_oe)
        else $error("output not driven while selected");
    chk_count_steps: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        shift_now && (cnt_q != 12'hfff) |=> cnt_q == $past(cnt_q) + 12'h001)
        else $error("shift count not advanced");
    chk_busy_pulse: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        shift_now |=> !shift_busy)
        else $error("shift pulse longer than one cycle");
    chk_wrap_position: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        shift_now && (pos_q == PW'(LOOP_BITS - 1)) |=> pos_q == '0)
        else $error("position did not wrap");
endmodule

// ==== rtl/ccdm_map.svh ====
/*
 Constants for the recirculating serial memory: geometry, pin filter depth
 and warm-up count. Assumes inclusion by rtl/ccdm_top.sv and by the type package.
*/
`ifndef CCDM_MAP_SVH
`define CCDM_MAP_SVH
`define CCDM_NUM_LOOPS 64
`define CCDM_LOOP_BITS 256
`define CCDM_ADDR_W 6
`define CCDM_WARMUP_SHIFTS 4000
`define CCDM_SYNC_STAGES 3
`endif

// ==== rtl/ccdm_pkg.sv ====
/*
 Types for the recirculating serial memory.
 Assumes the constants of ccdm_map.svh.
*/
`include "ccdm_map.svh"
package ccdm_pkg;
    typedef logic [`CCDM_ADDR_W-1:0] ccdm_addr_t;
    typedef logic [`CCDM_NUM_LOOPS-1:0] ccdm_word_t;
endpackage

// ==== sim/ccdm_ctl.sv ====
/*
 Controller model: drives the four phase lines, pulsing only phase two and four, one shift per step call.
 Assumes the bench calls step() and that clk runs.
*/
module ccdm_ctl (
    input wire logic clk,
    output logic phase1,
    output logic phase2,
    output logic phase3,
    output logic phase4
);
    timeunit 1ns;
    timeprecision 1ns;
    logic odd = 1'b0;
    initial {phase1, phase2, phase3, phase4} = 4'h0;
    // -----------------------------
    // Shift cycle
    // -----------------------------
    // Phase two and phase four rise in turn; 5 clocks per level beats the pin filter
    task automatic step();
        repeat (5) @(posedge clk);
        {phase1, phase2, phase3, phase4} <= odd ? 4'h1 : 4'h4;
        repeat (5) @(posedge clk);
        {phase1, phase2, phase3, phase4} <= 4'h0;
        odd = ~odd;
    endtask
endmodule

// ==== sim/tb_ccdm_top.sv ====
/*
 Bench for the serial memory: warm-up, writes, recirculation, read-back.
 Assumes ccdm_top and the controller model ccdm_ctl.
*/
module tb_ccdm_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, phase1, phase2, phase3, phase4;
    logic [5:0] addr;
    logic chip_sel, chip_en, wr_en, data_in, data_out_n, data_out_n_oe;
    logic shift_busy, chk_now;
    logic [11:0] shift_count;
    logic mem [64][256];
    logic expq [$];
    int p = 0;
    int bad_count = 0;
    int n_tests = 0;
    int n_busy = 0;
    logic dout_pin;
    // Open-drain pin with its pull-up: high whenever the block lets go
    assign dout_pin = data_out_n_oe ? data_out_n : 1'b1;
    // -----------------------------
    // Bench
    // -----------------------------
    ccdm_ctl ccdm_ctl_i (.clk(clk), .phase1(phase1), .phase2(phase2),
        .phase3(phase3), .phase4(phase4));
    ccdm_top ccdm_top_i (.clk(clk), .rst(rst), .phase1(phase1), .phase2(phase2),
        .phase3(phase3), .phase4(phase4), .addr(addr), .chip_sel(chip_sel),
        .chip_en(chip_en), .wr_en(wr_en), .data_in(data_in), .data_out_n(data_out_n),
        .data_out_n_oe(data_out_n_oe), .shift_busy(shift_busy),
        .shift_count(shift_count));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) if (chk_now) check("dout", dout_pin, expq.pop_front());
    always @(posedge clk) if (shift_busy) n_busy++;
    task automatic probe(logic b);
        expq.push_back(~b);
        chk_now <= 1'b1;
        @(posedge clk);
        chk_now <= 1'b0;
        check("oe", data_out_n_oe, 1'b1);
    endtask
    // Waits cover the pin filter; nothing is touched near a shift
    task automatic acc(logic [5:0] a, logic cs, logic wr, logic d, logic rd);
        @(posedge clk);
        addr <= a;
        chip_sel <= cs;
        chip_en <= 1'b1;
        repeat (6) @(posedge clk);
        if (rd) probe(mem[a][p]);
        if (wr) begin
            wr_en <= 1'b1;
            data_in <= d;
            repeat (6) @(posedge clk);
            wr_en <= 1'b0;
            repeat (2) @(posedge clk);
            if (cs) mem[a][p] = d;
            if (rd) probe(mem[a][p]);
        end
        chip_en <= 1'b0;
        repeat (6) @(posedge clk);
        check("oe", data_out_n_oe, 1'b0);
        check("pin", dout_pin, 1'b1);
    endtask
    task automatic shift();
        ccdm_ctl_i.step();
        repeat (2) @(posedge clk);
        p = (p + 1) % 256;
    endtask
    initial begin
        int k;
        int a;
        {rst, addr, chip_sel, chip_en, wr_en, data_in, chk_now} = 12'h800;
        void'($urandom(32'h486f));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        repeat (4000) shift();
        check("count", shift_count, 12'd4000);
        check("busy", 12'(n_busy), 12'd4000);
        for (k = 0; k < 3; k++) begin
            for (a = 0; a < 64; a++) acc(6'(a), 1'b1, 1'b1, 1'($urandom), 1'b0);
            if (k == 0) acc(6'h00, 1'b0, 1'b1, ~mem[0][p], 1'b0);
            shift();
        end
        repeat (253) shift();
        // Full lap of 256 shifts: data must come back intact in every loop
        for (k = 0; k < 3; k++) begin
            for (a = 0; a < 64; a++) acc(6'(a), 1'b1, a[0], 1'($urandom), 1'b1);
            shift();
        end
        check("count_sat", shift_count, 12'hfff);
        print_verdict();
    end
endmodule
